/* File: hw/eic_defines.svh */
// register map, field positions and filter counts of the external interrupt stage
`ifndef EIC_DEFINES_SVH
`define EIC_DEFINES_SVH

// control register location and reset value
`define EIC_CTRL_ADDR   12'h037
`define EIC_SFR_LO      12'h000
`define EIC_SFR_HI      12'h03f
`define EIC_DBR_LO      12'hf80
`define EIC_CTRL_RESET  8'h00

// control register fields
`define EIC_NS_BIT      7
`define EIC_PF_BIT      6
`define EIC_C_TRG_HI    5
`define EIC_C_TRG_LO    4
`define EIC_D_TRG_HI    3
`define EIC_D_TRG_LO    2
`define EIC_B_EDGE_BIT  1
`define EIC_CTRL_MASK   8'hfe

// filter bounds in high_freq_clock periods, the clock runs at that rate
`define EIC_A_REJ_FC    2
`define EIC_A_ACC_FC    7
`define EIC_B0_REJ_FC   63
`define EIC_B0_ACC_FC   193
`define EIC_B1_REJ_FC   15
`define EIC_B1_ACC_FC   49
`define EIC_CD_REJ_FC   7
`define EIC_CD_ACC_FC   25
`define EIC_SEL_MAX_FC  26

// stable-sample counts sit between the reject and accept bounds
`define EIC_A_THR   8'((`EIC_A_REJ_FC + `EIC_A_ACC_FC) / 2)
`define EIC_B0_THR  8'((`EIC_B0_REJ_FC + `EIC_B0_ACC_FC) / 2)
`define EIC_B1_THR  8'((`EIC_B1_REJ_FC + `EIC_B1_ACC_FC) / 2)
`define EIC_CD_THR  8'((`EIC_CD_REJ_FC + `EIC_CD_ACC_FC) / 2)

// slow mode: reject below 1 fs period, accept from 3.5 fs periods
`define EIC_SLOW_THR    8'h02
`define EIC_WARM_DONE   2'h3

`endif

/* File: hw/eic_pkg.sv */
// types of the external interrupt stage
package eic_pkg;

  // trigger codes of the two-bit trigger fields, in code order 00..11
  typedef enum logic [1:0] {
    EIC_TRG_RISE,
    EIC_TRG_FALL,
    EIC_TRG_BOTH,
    EIC_TRG_HIGH
  } eic_trig_t;

  // per-pin filter state
  typedef struct packed {
    logic       s1;
    logic       s2;
    logic       level;
    logic [1:0] warm;
    logic [7:0] cnt;
    logic       rise;
    logic       fall;
  } eic_filt_state_t;

  // top-level state
  typedef struct packed {
    logic [7:0] ctrl;
    logic [4:0] latch;
    logic [1:0] armed;
    logic [7:0] rdata;
  } eic_state_t;

endpackage : eic_pkg

/* File: hw/eic_filt_if.sv */
// link between the trigger logic and one noise filter
`timescale 1ns/1ps
interface eic_filt_if;
  logic       pin;
  logic [7:0] thresh;
  logic       slow;
  logic       fs_tick;
  logic       level;
  logic       rise;
  logic       fall;

  modport ctl  (output pin, output thresh, output slow, output fs_tick,
                input level, input rise, input fall);
  modport filt (input pin, input thresh, input slow, input fs_tick,
                output level, output rise, output fall);
endinterface : eic_filt_if

/* File: hw/eic_filter.sv */
// digital noise filter for one external interrupt pin
`timescale 1ns/1ps
module eic_filter
  import eic_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // filter link
  eic_filt_if.filt f
);
`include "eic_defines.svh"

  eic_filt_state_t q;
  eic_filt_state_t next_q;
  logic [7:0]      thr;

  // slow mode counts low_freq_clock ticks instead of fast cycles
  assign thr = f.slow ? `EIC_SLOW_THR : f.thresh;

  // synchronise, warm up, then flip only after thr stable samples
  always_comb begin
    next_q      = q;
    next_q.s1   = f.pin;
    next_q.s2   = q.s1;
    next_q.rise = 1'b0;
    next_q.fall = 1'b0;
    if (q.warm != `EIC_WARM_DONE) begin
      next_q.warm  = q.warm + 2'h1;
      next_q.level = q.s2;
      next_q.cnt   = 8'h00;
    end else if (q.s2 == q.level) begin
      next_q.cnt = 8'h00;
    end else if (!f.slow || f.fs_tick) begin
      if (q.cnt + 8'h01 >= thr) begin
        next_q.level = q.s2;
        next_q.rise  = q.s2;
        next_q.fall  = !q.s2;
        next_q.cnt   = 8'h00;
      end else begin
        next_q.cnt = q.cnt + 8'h01;
      end
    end
  end

  // state register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign f.level = q.level;
  assign f.rise  = q.rise;
  assign f.fall  = q.fall;

  // a level change needs a full run of stable samples behind it
  chk_filter_run: assert property (@(posedge ref_clk) disable iff (rst)
    (q.warm == `EIC_WARM_DONE) && ($past(q.warm) == `EIC_WARM_DONE) && $changed(q.level)
      |-> $past(q.cnt) + 8'h01 >= $past(thr))
    else $error("filter level changed before its run completed");

  // no edge is reported while the filter warms up after reset
  chk_filter_warm: assert property (@(posedge ref_clk) disable iff (rst)
    (q.warm != `EIC_WARM_DONE) |-> !q.rise && !q.fall)
    else $error("edge reported during warm-up");

endmodule : eic_filter

/* File: hw/eic_top.sv */
// external interrupt input stage: filters, triggers, latches, control register
`timescale 1ns/1ps
// Behaviour
// - five inputs, each with noise filter
// - shared pin is port input after reset
// - pin function bit: 0 port, 1 interrupt
// - a and e falling only, 2/7 fc
// - b filter 63/193 or 15/49 fc
// - c and d reject 7, accept 25
// - slow modes: 1 and 3.5 fs
// - latch set within establishment plus 6 fs
// - b edge bit: 0 rise, 1 fall
// - c/d codes rise, fall, both, high
// - requests gated by master and flags
// - port role never sets latch a
// - output changes on shared pin may fake requests
// - control register layout and reset
// - new b filter width within 26 fc
// - high level needs rising edge after reset
// - registers memory mapped in two areas; only the control register in the low area is decoded
// - latch holds until accepted or cleared
module eic_top
  import eic_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,

  // register access from the core
  input  wire logic [11:0] sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,

  // clock mode
  input  wire logic       slow_mode,
  input  wire logic       fs_tick,

  // external pins
  input  wire logic       ext_irq_a_n,
  input  wire logic       ext_irq_b,
  input  wire logic       ext_irq_c,
  input  wire logic       ext_irq_d,
  input  wire logic       ext_irq_e_n,
  output logic            shared_port_bit_in,
  output logic            pin_function_irq,

  // enables from the core interrupt controller
  input  wire logic       master_irq_enable,
  input  wire logic       enable_flag_a,
  input  wire logic       enable_flag_b,
  input  wire logic       enable_flag_c,
  input  wire logic       enable_flag_d,
  input  wire logic       enable_flag_e,
  input  wire logic       shared_source_select,

  // latches
  input  wire logic [4:0] latch_clear,
  output logic      [4:0] latch_irq,
  output logic      [4:0] irq_req
);
`include "eic_defines.svh"

  eic_state_t q;
  eic_state_t next_q;

  eic_filt_if fi [5] ();

  logic [4:0] pin_vec;
  logic [7:0] thr_vec [5];
  logic [4:0] lvl;
  logic [4:0] rise;
  logic [4:0] fall;
  logic [4:0] ev;
  logic [4:0] en;
  logic       pf;
  logic       ctrl_hit;
  logic       area_hit;
  eic_trig_t  trg_c;
  eic_trig_t  trg_d;

  // decoded control fields
  assign pf    = q.ctrl[`EIC_PF_BIT];
  assign trg_c = eic_trig_t'(q.ctrl[`EIC_C_TRG_HI:`EIC_C_TRG_LO]);
  assign trg_d = eic_trig_t'(q.ctrl[`EIC_D_TRG_HI:`EIC_D_TRG_LO]);

  // the shared pin feeds the port path always, the filter only in irq role
  assign shared_port_bit_in = ext_irq_a_n;
  assign pin_function_irq   = pf;
  assign pin_vec = {ext_irq_e_n, ext_irq_d, ext_irq_c, ext_irq_b,
                    pf ? ext_irq_a_n : 1'b1};

  // filter widths; the b select takes effect on the next sample
  assign thr_vec[0] = `EIC_A_THR;
  assign thr_vec[1] = q.ctrl[`EIC_NS_BIT] ? `EIC_B1_THR : `EIC_B0_THR;
  assign thr_vec[2] = `EIC_CD_THR;
  assign thr_vec[3] = `EIC_CD_THR;
  assign thr_vec[4] = `EIC_A_THR;

  // one synchronising noise filter per pin
  for (genvar g = 0; g < 5; g++) begin : g_filt
    assign fi[g].pin     = pin_vec[g];
    assign fi[g].thresh  = thr_vec[g];
    assign fi[g].slow    = slow_mode;
    assign fi[g].fs_tick = fs_tick;
    assign lvl[g]        = fi[g].level;
    assign rise[g]       = fi[g].rise;
    assign fall[g]       = fi[g].fall;

    eic_filter u_filt (
      .ref_clk (ref_clk),
      .rst     (rst),
      .f       (fi[g])
    );
  end

  // trigger test for the two-bit trigger fields
  function automatic logic trig_hit(
    input eic_trig_t mode,
    input logic      r,
    input logic      fl,
    input logic      level,
    input logic      armed
  );
    logic hit;
    hit = 1'b0;
    unique case (mode)
      EIC_TRG_RISE: hit = r;
      EIC_TRG_FALL: hit = fl;
      EIC_TRG_BOTH: hit = r | fl;
      EIC_TRG_HIGH: hit = level & (armed | r);
    endcase
    return hit;
  endfunction : trig_hit

  // qualified events per input
  always_comb begin
    ev[0] = fall[0] & pf;
    ev[1] = q.ctrl[`EIC_B_EDGE_BIT] ? fall[1] : rise[1];
    ev[2] = trig_hit(trg_c, rise[2], fall[2], lvl[2], q.armed[0]);
    ev[3] = trig_hit(trg_d, rise[3], fall[3], lvl[3], q.armed[1]);
    ev[4] = fall[4];
  end

  // register decode inside the special function area
  assign ctrl_hit = (sfr_addr == `EIC_CTRL_ADDR);
  assign area_hit = (sfr_addr <= `EIC_SFR_HI);

  // next state
  always_comb begin
    next_q = q;
    // control register write, unused bit 0 kept at zero
    if (sfr_wr && ctrl_hit) begin
      next_q.ctrl = sfr_wdata & `EIC_CTRL_MASK;
    end
    // read data is registered; anything but the control register reads zero
    if (sfr_rd) begin
      next_q.rdata = (ctrl_hit && area_hit) ? q.ctrl : 8'h00;
    end
    // high-level mode arms on a rising edge and disarms on a falling one
    if (rise[2]) begin
      next_q.armed[0] = 1'b1;
    end else if (fall[2]) begin
      next_q.armed[0] = 1'b0;
    end
    if (rise[3]) begin
      next_q.armed[1] = 1'b1;
    end else if (fall[3]) begin
      next_q.armed[1] = 1'b0;
    end
    // a new event wins over a clear in the same cycle
    next_q.latch = (q.latch & ~latch_clear) | ev;
  end

  // state register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q      <= '0;
      q.ctrl <= `EIC_CTRL_RESET;
    end else begin
      q <= next_q;
    end
  end

  // enable gating toward the core; clearing a flag masks pin glitches
  assign en = {enable_flag_e,
               enable_flag_d,
               enable_flag_c & shared_source_select,
               enable_flag_b,
               enable_flag_a & pf} & {5{master_irq_enable}};

  assign irq_req   = q.latch & en;
  assign latch_irq = q.latch;
  assign sfr_rdata = q.rdata;

  // named sequences for the latch and control write checks
  sequence s_fall_a;
    fall[0] && pf;
  endsequence

  sequence s_ctrl_write;
    sfr_wr && ctrl_hit;
  endsequence

  sequence s_hold_latch(int k);
    q.latch[k] && !latch_clear[k];
  endsequence

  // latch a only ever follows a falling edge in the interrupt role
  chk_latch_a_cause: assert property (@(posedge ref_clk) disable iff (rst)
    !$past(q.latch[0]) && q.latch[0] |-> $past(fall[0]) && $past(pf))
    else $error("latch a set without a qualified falling edge");

  // port role blocks latch a completely
  chk_port_role: assert property (@(posedge ref_clk) disable iff (rst)
    !pf && !q.latch[0] |=> !q.latch[0])
    else $error("latch a set while pin is a port");

  // a qualified falling edge on a sets its latch on the next edge
  chk_fall_sets_a: assert property (@(posedge ref_clk) disable iff (rst)
    s_fall_a |=> q.latch[0])
    else $error("falling edge on a did not set its latch");

  // a written control value shows on the next edge and is read back
  chk_ctrl_write: assert property (@(posedge ref_clk) disable iff (rst)
    s_ctrl_write ##1 (sfr_rd && ctrl_hit && !sfr_wr)
      |=> sfr_rdata == ($past(sfr_wdata, 2) & `EIC_CTRL_MASK))
    else $error("control register readback mismatch");

  // in rising mode a rising edge on b sets its latch on the next edge
  chk_b_edge: assert property (@(posedge ref_clk) disable iff (rst)
    !q.latch[1] && rise[1] && !q.ctrl[`EIC_B_EDGE_BIT] |=> q.latch[1])
    else $error("rising edge on b lost in rising mode");

  // a set latch stays set until cleared
  generate
    for (genvar k = 0; k < 5; k++) begin : g_chk
      chk_latch_hold: assert property (@(posedge ref_clk) disable iff (rst)
        s_hold_latch(k) |=> q.latch[k])
        else $error("latch dropped without a clear");
    end
  endgenerate

  // requests never pass without the master enable
  chk_req_gate: assert property (@(posedge ref_clk) disable iff (rst)
    |irq_req |-> master_irq_enable && (irq_req & ~q.latch) == 5'h00)
    else $error("request without master enable or latch");

  // high level on c keeps the latch set while the level stays armed
  chk_level_c: assert property (@(posedge ref_clk) disable iff (rst)
    trg_c == EIC_TRG_HIGH && lvl[2] && q.armed[0] |=> q.latch[2])
    else $error("high level on c not requesting");

  // a written b select reaches the filter width on the next edge
  chk_b_width: assert property (@(posedge ref_clk) disable iff (rst)
    s_ctrl_write |=> fi[1].thresh ==
      ($past(sfr_wdata[`EIC_NS_BIT]) ? `EIC_B1_THR : `EIC_B0_THR))
    else $error("b filter width does not follow its select");

  // unmapped addresses read as zero
  chk_unmapped_zero: assert property (@(posedge ref_clk) disable iff (rst)
    sfr_rd && !ctrl_hit |=> sfr_rdata == 8'h00)
    else $error("unmapped address returned data");

endmodule : eic_top

/* File: tb/eic_pin_src.sv */
// signal sources driving the five external interrupt pins
`timescale 1ns/1ps
module eic_pin_src (
  // clock
  input  wire logic       ref_clk,
  // pins: bit0 a (low active), 1 b, 2 c, 3 d, 4 e (low active)
  output logic      [4:0] pins
);
  // idle levels; the shared pin is only ever driven as a device input
  initial begin
    pins = 5'h11;
  end

  // level change just after a falling edge
  task automatic set_pin(input int idx, input logic val);
    @(negedge ref_clk);
    pins[idx] = val;
  endtask : set_pin

  // pulse of width cycles away from the present level
  task automatic pulse(input int idx, input int width);
    set_pin(idx, ~pins[idx]);
    repeat (width - 1) @(negedge ref_clk);
    set_pin(idx, ~pins[idx]);
  endtask : pulse
endmodule : eic_pin_src

/* File: tb/eic_top_tb.sv */
// self-checking bench of the external interrupt input stage
`timescale 1ns/1ps
module eic_top_tb;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] sfr_addr = 12'h000;
  logic        sfr_wr = 1'b0;
  logic        sfr_rd = 1'b0;
  logic [7:0]  sfr_wdata = 8'h00;
  logic [7:0]  sfr_rdata;
  logic        slow_mode = 1'b0;
  logic        fs_tick = 1'b0;
  logic [2:0]  fs_cnt = 3'h0;
  logic [4:0]  pins;
  logic        shared_port_bit_in;
  logic        pin_function_irq;
  logic [6:0]  en = 7'h7f;
  logic [4:0]  latch_clear = 5'h00;
  logic [4:0]  latch_irq;
  logic [4:0]  irq_req;
  logic [7:0]  ctrl_exp = 8'h00;
  int          error_cnt = 0;
  int          comparisons = 0;

  // clock at 20 MHz
  always #25 ref_clk = ~ref_clk;

  // low-frequency tick, one in eight cycles
  always @(negedge ref_clk) begin
    fs_cnt <= fs_cnt + 3'h1;
    fs_tick <= (fs_cnt == 3'h7);
  end

  eic_pin_src eic_pin_src_inst (.ref_clk(ref_clk), .pins(pins));

  eic_top eic_top_inst (
    .ref_clk(ref_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .slow_mode(slow_mode), .fs_tick(fs_tick),
    .ext_irq_a_n(pins[0]), .ext_irq_b(pins[1]), .ext_irq_c(pins[2]), .ext_irq_d(pins[3]),
    .ext_irq_e_n(pins[4]), .shared_port_bit_in(shared_port_bit_in),
    .pin_function_irq(pin_function_irq), .master_irq_enable(en[0]),
    .enable_flag_a(en[1]), .enable_flag_b(en[2]), .enable_flag_c(en[3]),
    .enable_flag_d(en[4]), .enable_flag_e(en[5]), .shared_source_select(en[6]),
    .latch_clear(latch_clear), .latch_irq(latch_irq), .irq_req(irq_req));

  // one comparison
  task automatic cmp(input logic [7:0] act, input logic [7:0] exp, input string what);
    comparisons++;
    if (act !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, act, exp);
    end
  endtask : cmp

  // latches and gated requests against the expected latch pattern
  task automatic check(input logic [4:0] lat);
    logic [4:0] gate;
    gate = {en[5], en[4], en[3] & en[6], en[2], en[1] & ctrl_exp[6]} & {5{en[0]}};
    cmp({3'h0, latch_irq}, {3'h0, lat}, "latch");
    cmp({3'h0, irq_req}, {3'h0, lat & gate}, "request");
  endtask : check

  // register write, one strobe cycle
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic keep;
    keep = en[0];
    @(negedge ref_clk);
    if (a == 12'h037) en[0] = 1'b0;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
    en[0] = keep;
    if (a == 12'h037) ctrl_exp = d & 8'hfe;
  endtask : wr

  // register read and compare once the data has landed
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge ref_clk);
    sfr_rd = 1'b0;
    @(negedge ref_clk);
    cmp(sfr_rdata, exp, "read data");
  endtask : rd

  // latch clear pulse, then idle cycles
  task automatic clr(input logic [4:0] m, input int idle);
    @(negedge ref_clk);
    latch_clear = m;
    @(negedge ref_clk);
    latch_clear = 5'h00;
    repeat (idle) @(negedge ref_clk);
  endtask : clr

  // reset values, reserved bit, foreign addresses
  task automatic t_regs;
    rd(12'h037, 8'h00);
    cmp({7'h0, pin_function_irq}, 8'h00, "pin role after reset");
    wr(12'h037, 8'hff);
    rd(12'h037, 8'hfe);
    cmp({7'h0, pin_function_irq}, 8'h01, "pin role set");
    wr(12'h036, 8'h00);
    rd(12'h037, 8'hfe);
    // back-to-back write and read of the control register
    @(negedge ref_clk);
    sfr_addr = 12'h037;
    sfr_wdata = 8'hc5;
    sfr_wr = 1'b1;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
    sfr_rd = 1'b1;
    @(negedge ref_clk);
    sfr_rd = 1'b0;
    ctrl_exp = 8'hc4;
    @(negedge ref_clk);
    cmp(sfr_rdata, 8'hc4, "write then read");
    rd(12'hfea, 8'h00);
    wr(12'h037, 8'h00);
  endtask : t_regs

  // shared pin in port role never sets latch a
  task automatic t_port_role;
    eic_pin_src_inst.set_pin(0, 1'b0);
    repeat (20) @(negedge ref_clk);
    cmp({7'h0, shared_port_bit_in}, 8'h00, "port copy");
    check(5'h00);
    eic_pin_src_inst.set_pin(0, 1'b1);
    repeat (20) @(negedge ref_clk);
  endtask : t_port_role

  // a and e: short pulse refused, long one latched, gating and hold
  task automatic t_a_e;
    wr(12'h037, 8'h40);
    for (int i = 0; i < 5; i += 4) begin
      eic_pin_src_inst.pulse(i, 1);
      repeat (20) @(negedge ref_clk);
      check(5'h00);
      eic_pin_src_inst.pulse(i, 7);
      repeat (12) @(negedge ref_clk);
      check(5'(1 << i));
      en[0] = 1'b0;
      repeat (30) @(negedge ref_clk);
      check(5'(1 << i));
      en[0] = 1'b1;
      en[6:1] = 6'h00;
      @(negedge ref_clk);
      check(5'(1 << i));
      en[6:1] = 6'h3f;
      clr(5'(1 << i), 2);
      check(5'h00);
    end
  endtask : t_a_e

  // b: both filter widths and both edges
  task automatic t_b;
    wr(12'h037, 8'h80);
    eic_pin_src_inst.pulse(1, 10);
    repeat (60) @(negedge ref_clk);
    check(5'h00);
    eic_pin_src_inst.pulse(1, 60);
    check(5'h02);
    clr(5'h02, 60);
    check(5'h00);
    wr(12'h037, 8'h02);
    repeat (26) @(negedge ref_clk);
    eic_pin_src_inst.pulse(1, 40);
    repeat (200) @(negedge ref_clk);
    check(5'h00);
    eic_pin_src_inst.set_pin(1, 1'b1);
    repeat (210) @(negedge ref_clk);
    check(5'h00);
    eic_pin_src_inst.set_pin(1, 1'b0);
    repeat (200) @(negedge ref_clk);
    check(5'h02);
    clr(5'h02, 2);
  endtask : t_b

  // c and d: level after reset, short pulse, every trigger code
  task automatic t_cd;
    wr(12'h037, 8'h30);
    repeat (30) @(negedge ref_clk);
    check(5'h00);
    eic_pin_src_inst.pulse(2, 30);
    repeat (30) @(negedge ref_clk);
    check(5'h04);
    en[6] = 1'b0;
    @(negedge ref_clk);
    check(5'h04);
    en[6] = 1'b1;
    eic_pin_src_inst.set_pin(2, 1'b0);
    repeat (30) @(negedge ref_clk);
    clr(5'h04, 5);
    check(5'h00);
    wr(12'h037, 8'h28);
    eic_pin_src_inst.pulse(2, 5);
    repeat (30) @(negedge ref_clk);
    check(5'h00);
    for (int c = 0; c < 4; c++) begin
      wr(12'h037, {2'h0, 2'(c), 2'(c), 2'h0});
      eic_pin_src_inst.set_pin(2, 1'b1);
      eic_pin_src_inst.set_pin(3, 1'b1);
      repeat (30) @(negedge ref_clk);
      check((c != 1) ? 5'h0c : 5'h00);
      clr(5'h0c, 5);
      check((c == 3) ? 5'h0c : 5'h00);
      eic_pin_src_inst.set_pin(2, 1'b0);
      eic_pin_src_inst.set_pin(3, 1'b0);
      repeat (30) @(negedge ref_clk);
      check((c != 0) ? 5'h0c : 5'h00);
      clr(5'h0c, 5);
      check(5'h00);
    end
  endtask : t_cd

  // slow mode: filter counts low-frequency ticks
  task automatic t_slow;
    wr(12'h037, 8'h40);
    slow_mode = 1'b1;
    eic_pin_src_inst.pulse(4, 4);
    repeat (40) @(negedge ref_clk);
    check(5'h00);
    eic_pin_src_inst.pulse(4, 40);
    repeat (30) @(negedge ref_clk);
    check(5'h10);
    clr(5'h10, 2);
    slow_mode = 1'b0;
  endtask : t_slow

  // verdict and end of run
  task automatic end_of_test;
    $display("errors %0d, comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  // watchdog well past the expected run of about 1700 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    end_of_test();
  end

  // main sequence; pin c is already high when reset is released
  initial begin
    eic_pin_src_inst.set_pin(2, 1'b1);
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    repeat (6) @(negedge ref_clk);
    check(5'h00);
    t_regs();
    t_port_role();
    t_a_e();
    t_b();
    t_cd();
    t_slow();
    end_of_test();
  end
endmodule : eic_top_tb
